//--- dv/prsf_mac_model.sv
// Receiving MAC model that stalls at random and keeps every byte.
`timescale 1ns/1ps
module prsf_mac_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] mac_data,
    input wire logic mac_valid,
    output logic mac_ready
);
    logic [7:0] got[$];
    int seed = 7;
    // Stalls one cycle in four so the two-entry buffer really fills.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mac_ready <= 1'b0;
        end else begin
            if (mac_valid && mac_ready) begin
                got.push_back(mac_data);
            end
            mac_ready <= ($random(seed) % 4) != 0;
        end
    end
endmodule

//--- dv/prsf_top_sva.sv
// Port checker for the receive timestamp filter.
`timescale 1ns/1ps
module prsf_top_sva (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic msg_valid,
    input wire logic msg_is_l2,
    input wire logic [63:0] msg_stamp,
    input wire logic [7:0] mac_data,
    input wire logic mac_valid,
    input wire logic mac_ready,
    input wire logic stamp_valid,
    input wire logic [63:0] stamp_value,
    input wire logic insert_req,
    input wire logic append_req,
    input wire logic [63:0] insert_stamp
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_rd_quiet: assert property (
        !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("stray data");
    a_one_route: assert property (
        !(stamp_valid && insert_req)) else $error("both routes");
    a_append_pair: assert property (
        append_req |-> insert_req && $past(msg_is_l2))
        else $error("bad append");
    a_stamp_cause: assert property (
        stamp_valid |-> $past(msg_valid) && stamp_value == $past(msg_stamp))
        else $error("bad stamp");
    a_insert_cause: assert property (
        insert_req |-> $past(msg_valid) && insert_stamp == $past(msg_stamp))
        else $error("bad insert");
    a_readout_hold: assert property (
        !stamp_valid |-> $stable(stamp_value)) else $error("readout moved");
    a_no_spurious: assert property (
        !$past(msg_valid) |-> !stamp_valid && !insert_req)
        else $error("stamp without message");
    a_mac_hold: assert property (
        mac_valid && !mac_ready |=> mac_valid && $stable(mac_data))
        else $error("byte lost on stall");
    c_stamp: cover property (stamp_valid);
    c_append: cover property (append_req);
    c_stall: cover property (mac_valid && !mac_ready);
endmodule

//--- dv/prsf_top_test.sv
// Self-checking bench for the receive timestamp filter.
`timescale 1ns/1ps
module prsf_top_test;
    import prsf_pkg::*;
    logic clk_sys, rst_n, reg_wr, reg_rd, med_valid, med_sop, med_eop;
    logic med_preamble, med_ready, msg_valid, msg_is_ip, msg_is_l2;
    logic msg_udp_err, msg_fcs_err, mac_valid, mac_sop, mac_eop, mac_ready;
    logic stamp_valid, insert_req, append_req;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, b, x, f, r;
    logic [7:0] med_data, msg_first_byte, msg_domain, mac_data;
    logic [31:0] msg_ip_dest;
    logic [63:0] msg_stamp, stamp_value, insert_stamp;
    logic q;
    int seed = 91;
    int err_total, checks, n;
    prsf_top dut (.*);
    prsf_mac_model mac (.clk_sys(clk_sys), .rst_n(rst_n),
        .mac_data(mac_data), .mac_valid(mac_valid), .mac_ready(mac_ready));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic give_verdict;
        $display("checks=%0d errors=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
        @(posedge clk_sys);
    endtask
    // Holds the byte until the edge at which the buffer takes it or the gap keeper drops it.
    task automatic send(input logic [7:0] d, input logic s, e, p);
        logic t;
        med_data <= d;
        med_sop <= s;
        med_eop <= e;
        med_preamble <= p;
        med_valid <= 1'b1;
        for (int i = 0; i < 200; i++) begin
            @(negedge clk_sys);
            t = med_ready;
            @(posedge clk_sys);
            if (t) return;
        end
        err_total++;
        give_verdict();
    endtask
    // Two frames with four preamble bytes right after the first one.
    task automatic stream(input logic keep);
        logic [7:0] e[$], v;
        int i;
        mac.got.delete();
        for (i = 0; i < 16; i++) begin
            v = (i > 5 && i < 10) ? 8'h55 : {1'b1, 7'($random(seed))};
            send(v, i == 0 || i == 10, i == 5 || i == 15, v == 8'h55);
            if (keep || v != 8'h55) e.push_back(v);
        end
        med_valid <= 1'b0;
        for (i = 0; i < 900 && mac.got.size() < e.size(); i++)
            @(posedge clk_sys);
        chk(16'(mac.got.size()), 16'(e.size()));
        for (i = 0; i < e.size() && i < mac.got.size(); i++)
            chk({8'h00, mac.got[i]}, {8'h00, e[i]});
        $display("stream test done");
    endtask
    function automatic logic qual(input logic [15:0] b, f, x);
        return b[0] && (msg_first_byte & f[15:8]) == (f[7:0] & f[15:8])
            && (!b[12] || !msg_is_ip || msg_ip_dest == 32'he0000181)
            && (!b[15] || msg_domain == x[7:0])
            && (!msg_udp_err || x[11]) && (!msg_fcs_err || x[10]);
    endfunction
    initial begin
        {rst_n, reg_wr, reg_rd, med_valid, med_sop, med_eop} = '0;
        {med_preamble, msg_valid, msg_is_ip, msg_is_l2} = '0;
        {msg_udp_err, msg_fcs_err, reg_addr, reg_wdata, med_data} = '0;
        {msg_first_byte, msg_domain, msg_ip_dest, msg_stamp} = '0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd(5'h1a, r);
        chk(r, 16'h0000);
        rd(5'h1b, r);
        chk(r, 16'h0000);
        rd(5'h1c, r);
        chk(r, 16'hc000);
        rd(5'h05, r);
        chk(r, 16'h0000);
        wr(5'h19, 16'h0000);
        wr(5'h1b, 16'he000);
        wr(5'h19, 16'h2000);
        wr(5'h1b, 16'h0181);
        rd(5'h1b, r);
        chk(r, 16'h0181);
        wr(5'h19, 16'h0000);
        rd(5'h1b, r);
        chk(r, 16'he000);
        $display("register test done");
        for (n = 0; n < 60; n++) begin
            r = 16'($random(seed));
            b = {r[0], 2'b00, r[1], 11'h000, r[2] | r[3]};
            f = {(n % 4 == 0) ? 8'h00 : 8'($random(seed)), 8'($random(seed))};
            x = {4'hc, r[7:4], 8'($random(seed))};
            wr(5'h19, b);
            wr(5'h1a, f);
            wr(5'h1c, x);
            msg_first_byte <= r[8] ? f[7:0] : 8'($random(seed));
            msg_domain <= r[9] ? x[7:0] : 8'($random(seed));
            msg_ip_dest <= r[10] ? 32'he0000181 : 32'($random(seed));
            {msg_is_ip, msg_is_l2, msg_udp_err, msg_fcs_err} <= r[15:12];
            msg_stamp <= {32'($random(seed)), 32'($random(seed))};
            msg_valid <= 1'b1;
            @(posedge clk_sys);
            msg_valid <= 1'b0;
            q = qual(b, f, x);
            @(negedge clk_sys);
            chk(stamp_valid, q && !x[8]);
            chk(insert_req, q && x[8]);
            chk(append_req, q && x[8] && x[9] && r[14]);
            @(posedge clk_sys);
        end
        $display("message test done");
        stream(1'b0);
        wr(5'h1c, 16'h0000);
        stream(1'b1);
        give_verdict();
    end
endmodule
bind prsf_top prsf_top_sva chk_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .msg_valid(msg_valid),
    .msg_is_l2(msg_is_l2), .msg_stamp(msg_stamp), .mac_data(mac_data),
    .mac_valid(mac_valid), .mac_ready(mac_ready),
    .stamp_valid(stamp_valid), .stamp_value(stamp_value),
    .insert_req(insert_req), .append_req(append_req),
    .insert_stamp(insert_stamp));

//--- logic/prsf_pkg.sv
// Package with register map, field layout and timing constants.
package prsf_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam logic [4:0] OFS_BASE_CFG = 5'h19;
    localparam logic [4:0] OFS_FIRST_BYTE = 5'h1a;
    localparam logic [4:0] OFS_IP_DATA = 5'h1b;
    localparam logic [4:0] OFS_EXT_CFG = 5'h1c;
    localparam logic [4:0] OFS_STATUS = 5'h1d;
    localparam int MASK_HI = 15;
    localparam int MASK_LO = 8;
    localparam int BASE_DOMAIN_EN = 15;
    localparam int BASE_IP_SEL = 13;
    localparam int BASE_IP_EN = 12;
    localparam int BASE_TS_EN = 0;
    localparam int EXT_GAP_HI = 15;
    localparam int EXT_GAP_LO = 12;
    localparam int EXT_KEEP_UDP = 11;
    localparam int EXT_KEEP_FCS = 10;
    localparam int EXT_APPEND = 9;
    localparam int EXT_INSERT = 8;
    localparam logic [15:0] RST_FIRST_BYTE = 16'h0000;
    localparam logic [15:0] RST_IP_DATA = 16'h0000;
    localparam logic [15:0] RST_BASE_CFG = 16'h0000;
    localparam logic [15:0] RST_EXT_CFG = 16'hc000;
    localparam int STAMP_LEN_BYTES = 8;
    localparam int BYTE_NS = 80;
    localparam int CLK_NS = 20;
    localparam int BYTE_CYCLES = (BYTE_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [1:0] {
        PRSF_IDLE = 2'b00,
        PRSF_FRAME = 2'b01,
        PRSF_GAP = 2'b10
    } prsf_state_t;
endpackage

//--- logic/prsf_skid.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module prsf_skid #(
    parameter int W = 10
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [W-1:0] mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

//--- logic/prsf_tick.sv
// Divider giving a one-cycle pulse per byte time.
`timescale 1ns/1ps
module prsf_tick #(
    parameter int DIV = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    output logic tick
);
    logic [7:0] cnt;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 8'h00;
            tick <= 1'b0;
        end else if (cnt == 8'(DIV - 1)) begin
            cnt <= 8'h00;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + 8'h01;
            tick <= 1'b0;
        end
    end
endmodule

//--- logic/prsf_top.sv
// Receive timestamp filter, gap keeper and configuration registers.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module prsf_top
    import prsf_pkg::*;
#(
    parameter int MIN_GAP_W = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [prsf_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [prsf_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [prsf_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [7:0] med_data,
    input wire logic med_valid,
    input wire logic med_sop,
    input wire logic med_eop,
    input wire logic med_preamble,
    output logic med_ready,
    input wire logic msg_valid,
    input wire logic [7:0] msg_first_byte,
    input wire logic [7:0] msg_domain,
    input wire logic [31:0] msg_ip_dest,
    input wire logic msg_is_ip,
    input wire logic msg_is_l2,
    input wire logic msg_udp_err,
    input wire logic msg_fcs_err,
    input wire logic [63:0] msg_stamp,
    output logic [7:0] mac_data,
    output logic mac_valid,
    output logic mac_sop,
    output logic mac_eop,
    input wire logic mac_ready,
    output logic stamp_valid,
    output logic [63:0] stamp_value,
    output logic insert_req,
    output logic append_req,
    output logic [63:0] insert_stamp
);
    logic [15:0] base_cfg;
    logic [15:0] first_byte_cfg;
    logic [31:0] ip_filter;
    logic [15:0] ext_cfg;
    logic [15:0] next_rdata;
    logic [7:0] first_byte_mask;
    logic [7:0] first_byte_match_value;
    logic ip_half_select;
    logic [MIN_GAP_W-1:0] min_gap_bytes;
    logic stamp_insert_on;
    logic append_stamp_layer2;
    logic pass_first;
    logic pass_ip;
    logic pass_domain;
    logic pass_err;
    logic qualify;
    logic byte_tick;
    logic [MIN_GAP_W-1:0] gap_cnt;
    logic dropping;
    logic [15:0] stamp_count;
    logic [15:0] drop_count;
    logic in_valid;
    logic in_ready;
    logic [9:0] out_word;
    prsf_state_t state;

    assign first_byte_mask = first_byte_cfg[MASK_HI:MASK_LO];
    assign first_byte_match_value = first_byte_cfg[7:0];
    assign ip_half_select = base_cfg[BASE_IP_SEL];
    assign min_gap_bytes = ext_cfg[EXT_GAP_HI -: MIN_GAP_W];
    assign stamp_insert_on = ext_cfg[EXT_INSERT];
    assign append_stamp_layer2 = ext_cfg[EXT_APPEND];

    // Registers: software writes steer filtering below.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            base_cfg <= RST_BASE_CFG;
            first_byte_cfg <= RST_FIRST_BYTE;
            ext_cfg <= RST_EXT_CFG;
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_BASE_CFG: begin
                    base_cfg <= reg_wdata;
                end
                OFS_FIRST_BYTE: begin
                    first_byte_cfg <= reg_wdata;
                end
                OFS_EXT_CFG: begin
                    ext_cfg <= reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // The select bit lives in the base register, so the order of the
    // two halves is entirely up to software.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ip_filter <= {RST_IP_DATA, RST_IP_DATA};
        end else if (reg_wr && reg_addr == OFS_IP_DATA) begin
            if (ip_half_select) begin
                ip_filter[15:0] <= reg_wdata;
            end else begin
                ip_filter[31:16] <= reg_wdata;
            end
        end
    end

    always_comb begin
        next_rdata = 16'h0000;
        case (reg_addr)
            OFS_BASE_CFG: next_rdata = base_cfg;
            OFS_FIRST_BYTE: next_rdata = first_byte_cfg;
            OFS_IP_DATA: next_rdata = ip_half_select ?
                ip_filter[15:0] : ip_filter[31:16];
            OFS_EXT_CFG: next_rdata = ext_cfg;
            OFS_STATUS: next_rdata = {drop_count[7:0], stamp_count[7:0]};
            default: next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // Message qualification.
    assign pass_first = (first_byte_mask == 8'h00) ||
        (((msg_first_byte ^ first_byte_match_value) &
        first_byte_mask) == 8'h00);
    assign pass_ip = !base_cfg[BASE_IP_EN] || !msg_is_ip ||
        (msg_ip_dest == ip_filter);
    assign pass_domain = !base_cfg[BASE_DOMAIN_EN] ||
        (msg_domain == ext_cfg[7:0]);
    assign pass_err = (!msg_udp_err || ext_cfg[EXT_KEEP_UDP]) &&
        (!msg_fcs_err || ext_cfg[EXT_KEEP_FCS]);
    assign qualify = msg_valid && base_cfg[BASE_TS_EN] && pass_first &&
        pass_ip && pass_domain && pass_err;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stamp_valid <= 1'b0;
            stamp_value <= 64'h0;
            insert_req <= 1'b0;
            append_req <= 1'b0;
            insert_stamp <= 64'h0;
        end else begin
            stamp_valid <= qualify && !stamp_insert_on;
            insert_req <= qualify && stamp_insert_on;
            append_req <= qualify && stamp_insert_on &&
                append_stamp_layer2 && msg_is_l2;
            // The readout copy stays put while stamps go into packets.
            if (qualify && !stamp_insert_on) begin
                stamp_value <= msg_stamp;
            end
            if (qualify && stamp_insert_on) begin
                insert_stamp <= msg_stamp;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stamp_count <= 16'h0000;
            drop_count <= 16'h0000;
        end else if (msg_valid) begin
            if (qualify) begin
                stamp_count <= stamp_count + 16'h0001;
            end else begin
                drop_count <= drop_count + 16'h0001;
            end
        end
    end

    prsf_tick #(
        .DIV(BYTE_CYCLES)
    ) u_tick (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick(byte_tick)
    );

    // Gap keeper: after an end of packet, byte times are counted; preamble
    // bytes that arrive before the minimum is reached are dropped. Payload
    // is never dropped, which trades a short gap for frame integrity.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= PRSF_IDLE;
            gap_cnt <= '0;
        end else begin
            case (state)
                PRSF_IDLE: begin
                    if (med_valid && med_ready && med_sop) begin
                        state <= PRSF_FRAME;
                    end
                end
                PRSF_FRAME: begin
                    if (med_valid && med_ready && med_eop) begin
                        state <= PRSF_GAP;
                        gap_cnt <= '0;
                    end
                end
                PRSF_GAP: begin
                    if (byte_tick && gap_cnt != min_gap_bytes) begin
                        gap_cnt <= gap_cnt + 1'b1;
                    end
                    // A frame start kept during the gap must be tracked,
                    // or its end would open no gap.
                    if (med_valid && med_ready && med_sop && !dropping) begin
                        state <= PRSF_FRAME;
                    end else if (gap_cnt == min_gap_bytes) begin
                        state <= PRSF_IDLE;
                    end
                end
                default: begin
                    state <= PRSF_IDLE;
                end
            endcase
        end
    end

    assign dropping = (state == PRSF_GAP) && med_preamble &&
        (gap_cnt != min_gap_bytes);
    assign med_ready = dropping || in_ready;
    assign in_valid = med_valid && !dropping;

    prsf_skid #(
        .W(10)
    ) u_skid (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_data({med_sop, med_eop, med_data}),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .out_data(out_word),
        .out_valid(mac_valid),
        .out_ready(mac_ready)
    );

    assign mac_sop = out_word[9];
    assign mac_eop = out_word[8];
    assign mac_data = out_word[7:0];
endmodule
